// ==== design/codec_mute_ctrl.sv ====
// control port mode, clock ratio check and mute output of the codec
// Operation
// [R01] master clock is 128/256/384/512x fs base rate, 64/128/192/256x high rate
// [R02] ratio chosen by the two-bit clock ratio select field
// [R03] control clock times every control data bit in or out
// [R04] two-wire mode: data line driven only low, open drain
// [R05] four-wire mode: data pin is a pure input from the host
// [R06] port mode chosen from audio output pin level during reset
// [R07] pin is pulled-up input in reset; latched at release, low means two-wire
// [R08] two-wire mode: address pin gives the bus address lsb
// [R09] four-wire mode: address pin is active-low select framing transfers
// [R10] in reset: low power and all state back to defaults
// [R11] control port refuses all access while reset is held
// [R12] after reset release, control port and codec become operational
// [R13] mute low in init, power-down, reset, missing clock, bad frame ratio
// [R14] manual mute bit forces the mute output
// [R15] zero mute after 512 all-zero frames on all six inputs
// [R16] one non-zero sample on any input releases zero mute
// [R17] zero mute works only with its enable bit set
// [R18] slave frame clock runs at fs, synchronous to master clock
// [R19] mute output is the OR of faults, manual bit and zero mute
// [R20] zero counter counts all-zero frames, clears on non-zero or disable
`timescale 1ns/1ps
`default_nettype none
module codec_mute_ctrl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // control port pins
  input wire logic ctrl_serial_clock_i,
  input wire logic ctrl_serial_in_i,
  output logic ctrl_serial_out_o,
  output logic ctrl_serial_oe_o,
  input wire logic addr_bit_pin_i,
  // audio output pin, strap input during reset
  input wire logic audio_serial_out_i,
  output logic audio_serial_out_o,
  output logic audio_serial_out_oe_o,
  input wire logic audio_sdata_i,
  // frame clock pin
  input wire logic frame_clock_i,
  // control port core side
  input wire logic ctrl_tx_en_i,
  input wire logic ctrl_tx_bit_i,
  output logic four_wire_mode_o,
  output logic bus_addr_lsb_o,
  output logic ctrl_select_o,
  output logic ctrl_bit_strobe_o,
  output logic ctrl_bit_data_o,
  // configuration bits
  input wire logic [1:0] clock_ratio_select_i,
  input wire logic high_rate_mode_i,
  input wire logic power_down_i,
  input wire logic manual_mute_i,
  input wire logic zero_mute_enable_i,
  // dac samples
  input wire logic [codec_ctrl_pkg::CH_NUM-1:0][codec_ctrl_pkg::SAMPLE_W-1:0] dac_data_i,
  // status
  output logic codec_active_o,
  output logic low_power_o,
  output logic ratio_ok_o,
  output logic mute_out_n_o
);
  import codec_ctrl_pkg::*;

  typedef struct packed {
    phase_t phase;
    logic [INIT_W-1:0] init_cnt;
    logic mode_taken;
    logic four_wire;
    logic [2:0] sclk_s;
    logic [2:0] lr_s;
    logic [1:0] din_s;
    logic [1:0] ad_s;
    logic [1:0] aso_s;
    logic addr_lsb;
    logic sel;
    logic bit_stb;
    logic bit_dat;
    logic sda_oe;
    logic sda_out;
    logic aso_oe;
    logic aso_out;
    logic low_pwr;
    logic active;
    logic [RATIO_W-1:0] ratio_cnt;
    logic ratio_ok;
    logic frame_stb;
    logic all_zero;
    logic mute_n;
  } state_t;

  // everything at defaults, port closed, mute asserted
  localparam state_t ST_RESET = '{
    phase: PH_INIT,
    init_cnt: '0,
    mode_taken: 1'b0,
    four_wire: 1'b0,
    sclk_s: '0,
    lr_s: '0,
    din_s: '0,
    ad_s: '0,
    aso_s: {STRAP_PULL, STRAP_PULL},
    addr_lsb: 1'b0,
    sel: 1'b0,
    bit_stb: 1'b0,
    bit_dat: 1'b0,
    sda_oe: 1'b0,
    sda_out: 1'b0,
    aso_oe: 1'b0,
    aso_out: 1'b0,
    low_pwr: 1'b1,
    active: 1'b0,
    ratio_cnt: '0,
    ratio_ok: 1'b0,
    frame_stb: 1'b0,
    all_zero: 1'b0,
    mute_n: 1'b0
  };

  state_t st_r;
  state_t st_nxt;

  zero_mute_if zif ();

  logic [CH_NUM-1:0] ch_zero;
  logic [RATIO_W-1:0] exp_m1;
  logic sclk_rise;
  logic lr_rise;
  logic run;
  logic port_open;

  // per-channel zero compare
  for (genvar g = 0; g < CH_NUM; g++) begin : g_zero
    assign ch_zero[g] = (dac_data_i[g] == '0);
  end

  // expected frame length for the chosen ratio
  assign exp_m1 = high_rate_mode_i ? RATIO_HRM_M1[clock_ratio_select_i] // [R02]
                                   : RATIO_BRM_M1[clock_ratio_select_i]; // [R01]

  // edges taken from the second and third synchroniser stages, never the first
  assign sclk_rise = st_r.sclk_s[1] && !st_r.sclk_s[2];
  assign lr_rise = st_r.lr_s[1] && !st_r.lr_s[2];
  assign run = (st_r.phase == PH_RUN);
  // four-wire select is active low; two-wire port is always addressed
  assign port_open = run && (!st_r.four_wire || !st_r.ad_s[1]); // [R09]

  assign zif.frame_stb = st_r.frame_stb;
  assign zif.all_zero = st_r.all_zero;
  assign zif.enable = zero_mute_enable_i; // [R17]

  zero_mute_det u_zero (
    .clk_sys_i (clk_sys_i),
    .reset_i (reset_i),
    .zif (zif)
  );

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[1:0], ctrl_serial_clock_i};
    st_nxt.lr_s = {st_r.lr_s[1:0], frame_clock_i};
    st_nxt.din_s = {st_r.din_s[0], ctrl_serial_in_i};
    st_nxt.ad_s = {st_r.ad_s[0], addr_bit_pin_i};
    st_nxt.aso_s = {st_r.aso_s[0], audio_serial_out_i};
    st_nxt.bit_stb = 1'b0;
    st_nxt.frame_stb = 1'b0;

    // phase sequencing; strap settles through the synchroniser first
    case (st_r.phase)
      PH_INIT: begin
        if (st_r.init_cnt == MODE_SAMPLE_AT && !st_r.mode_taken) begin
          st_nxt.mode_taken = 1'b1;
          st_nxt.four_wire = (st_r.aso_s[1] != MODE_TWO_WIRE); // [R06] [R07]
        end
        if (st_r.init_cnt == INIT_CYCLES) begin
          st_nxt.phase = PH_RUN; // [R12]
        end else begin
          st_nxt.init_cnt = st_r.init_cnt + 8'h01;
        end
      end
      PH_RUN: begin
        if (power_down_i) begin
          st_nxt.phase = PH_PDN;
        end
      end
      PH_PDN: begin
        // leaving power-down goes through init again, mode kept
        if (!power_down_i) begin
          st_nxt.phase = PH_INIT;
          st_nxt.init_cnt = '0;
        end
      end
      default: begin
        st_nxt.phase = PH_INIT;
        st_nxt.init_cnt = '0;
      end
    endcase

    st_nxt.active = (st_nxt.phase == PH_RUN); // [R12]
    st_nxt.low_pwr = (st_nxt.phase != PH_RUN); // [R10]

    // pin role by mode
    st_nxt.addr_lsb = !st_r.four_wire && st_r.ad_s[1]; // [R08]
    st_nxt.sel = st_r.four_wire && !st_r.ad_s[1]; // [R09]

    // one data bit per control clock rising edge, only while open
    if (port_open && sclk_rise) begin
      st_nxt.bit_stb = 1'b1; // [R03] [R11]
      st_nxt.bit_dat = st_r.din_s[1];
    end

    // open drain: only ever pull low, never in four-wire mode
    st_nxt.sda_oe = run && !st_r.four_wire && ctrl_tx_en_i && !ctrl_tx_bit_i; // [R04] [R05]
    st_nxt.sda_out = 1'b0; // [R04]

    // audio output pin stays an input until running
    st_nxt.aso_oe = run; // [R07]
    st_nxt.aso_out = run && audio_sdata_i;

    // frame length check, counts master clocks between frame edges
    if (lr_rise) begin
      st_nxt.ratio_ok = (st_r.ratio_cnt == exp_m1); // [R13] [R18]
      st_nxt.ratio_cnt = '0;
      st_nxt.frame_stb = 1'b1;
      st_nxt.all_zero = &ch_zero; // [R15] [R16]
    end else begin
      // late edge or stopped frame clock counts as a bad ratio
      if (st_r.ratio_cnt >= exp_m1) begin
        st_nxt.ratio_ok = 1'b0; // [R13]
      end
      if (st_r.ratio_cnt != '1) begin
        st_nxt.ratio_cnt = st_r.ratio_cnt + 10'h001;
      end
    end

    // any mute cause pulls the output low
    st_nxt.mute_n = run && st_r.ratio_ok && !manual_mute_i && !zif.mute; // [R13] [R14] [R19]
  end

  // async reset forces defaults, the only path back to two-wire strap capture
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= ST_RESET; // [R10]
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign ctrl_serial_out_o = st_r.sda_out;
  assign ctrl_serial_oe_o = st_r.sda_oe;
  assign audio_serial_out_o = st_r.aso_out;
  assign audio_serial_out_oe_o = st_r.aso_oe;
  assign four_wire_mode_o = st_r.four_wire;
  assign bus_addr_lsb_o = st_r.addr_lsb;
  assign ctrl_select_o = st_r.sel;
  assign ctrl_bit_strobe_o = st_r.bit_stb;
  assign ctrl_bit_data_o = st_r.bit_dat;
  assign codec_active_o = st_r.active;
  assign low_power_o = st_r.low_pwr;
  assign ratio_ok_o = st_r.ratio_ok;
  assign mute_out_n_o = st_r.mute_n;

  // checks on the block's own behaviour
  sequence s_frame_late;
    !lr_rise && st_r.ratio_cnt >= exp_m1;
  endsequence

  sequence s_bad_frame;
    lr_rise && st_r.ratio_cnt != exp_m1;
  endsequence

  AST_MUTE_RATIO: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R13]
    (s_frame_late or s_bad_frame) |=> !ratio_ok_o ##1 !mute_out_n_o)
    else $error("bad frame ratio did not mute");

  AST_MUTE_MANUAL: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R14]
    manual_mute_i |=> !mute_out_n_o)
    else $error("manual mute ignored");

  AST_MUTE_OR: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R19]
    mute_out_n_o |-> $past(run) && $past(ratio_ok_o) && !$past(manual_mute_i) && !$past(zif.mute))
    else $error("mute released with a cause active");

  AST_OPEN_DRAIN: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R04]
    ctrl_serial_oe_o |-> !ctrl_serial_out_o && !four_wire_mode_o)
    else $error("control data driven high or in four-wire mode");

  AST_FOUR_WIRE_IN: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R05]
    four_wire_mode_o |=> !ctrl_serial_oe_o)
    else $error("control data driven in four-wire mode");

  AST_SELECT_GATE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R09]
    ctrl_bit_strobe_o && four_wire_mode_o |-> !$past(st_r.ad_s[1]))
    else $error("bit taken without select");

  AST_REJECT_INIT: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R11]
    !run |=> !ctrl_bit_strobe_o && !mute_out_n_o)
    else $error("port or audio live before init");

  AST_MODE_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R06]
    st_r.mode_taken |=> $stable(four_wire_mode_o))
    else $error("port mode changed after capture");

  AST_STRAP_PIN: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R07]
    !st_r.mode_taken |-> !audio_serial_out_oe_o)
    else $error("strap pin driven before capture");

  AST_BIT_CLOCK: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R03]
    ctrl_bit_strobe_o |-> $past(sclk_rise) && ctrl_bit_data_o == $past(st_r.din_s[1]))
    else $error("bit not timed by control clock");
endmodule
`default_nettype wire

// ==== design/codec_ctrl_pkg.sv ====
// constants and types shared by the codec control-side logic
package codec_ctrl_pkg;

  // audio side geometry
  localparam int CH_NUM = 6;
  localparam int SAMPLE_W = 24;

  // start-up sequencing after reset release
  localparam int INIT_W = 8;
  localparam logic [INIT_W-1:0] INIT_CYCLES = 8'h10;
  localparam logic [INIT_W-1:0] MODE_SAMPLE_AT = 8'h03;

  // strap level that selects the two-wire port
  localparam logic MODE_TWO_WIRE = 1'b0;
  // reset value of the strap synchroniser, as the weak pull-up
  localparam logic STRAP_PULL = 1'b1;

  // master-clock cycles per frame minus one, indexed by clock ratio select
  localparam int RATIO_W = 10;
  localparam logic [3:0][RATIO_W-1:0] RATIO_BRM_M1 = {10'h1ff, 10'h17f, 10'h0ff, 10'h07f};
  localparam logic [3:0][RATIO_W-1:0] RATIO_HRM_M1 = {10'h0ff, 10'h0bf, 10'h07f, 10'h03f};

  // zero-detect run length in frames
  localparam int ZCNT_W = 10;
  localparam logic [ZCNT_W-1:0] ZERO_RUN = 10'h200;

  // device operating phase
  typedef enum logic [2:0] {
    PH_INIT = 3'b001,
    PH_RUN = 3'b010,
    PH_PDN = 3'b100
  } phase_t;

endpackage

// ==== design/zero_mute_if.sv ====
// link between the frame logic and the zero-detect mute unit
`timescale 1ns/1ps
`default_nettype none
interface zero_mute_if;
  logic frame_stb;
  logic all_zero;
  logic enable;
  logic mute;

  // frame side feeds samples status, detector answers with mute
  modport ctl (output frame_stb, output all_zero, output enable, input mute);
  modport det (input frame_stb, input all_zero, input enable, output mute);
endinterface
`default_nettype wire

// ==== design/zero_mute_det.sv ====
// zero-run detector that raises an automatic mute
`timescale 1ns/1ps
`default_nettype none
module zero_mute_det (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // frame link
  zero_mute_if.det zif
);
  import codec_ctrl_pkg::*;

  typedef struct packed {
    logic [ZCNT_W-1:0] cnt;
    logic mute;
  } zstate_t;

  localparam zstate_t ZST_RESET = '{cnt: '0, mute: 1'b0};

  zstate_t st_r;
  zstate_t st_nxt;

  // one count per all-zero frame, saturating at the run length
  always_comb begin
    st_nxt = st_r;
    if (!zif.enable) begin
      st_nxt.cnt = '0; // [R17]
      st_nxt.mute = 1'b0;
    end else if (zif.frame_stb) begin
      if (zif.all_zero) begin
        if (st_r.cnt != ZERO_RUN) begin
          st_nxt.cnt = st_r.cnt + 10'h001; // [R20]
        end
        if (st_nxt.cnt == ZERO_RUN) begin
          st_nxt.mute = 1'b1; // [R15]
        end
      end else begin
        st_nxt.cnt = '0; // [R20]
        st_nxt.mute = 1'b0; // [R16]
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= ZST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign zif.mute = st_r.mute;

  sequence s_nonzero_frame;
    zif.frame_stb && !zif.all_zero;
  endsequence

  AST_ZERO_RELEASE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R16]
    s_nonzero_frame |=> !zif.mute && st_r.cnt == 10'h000)
    else $error("zero mute held after a non-zero frame");

  AST_ZERO_ENABLE: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R17]
    !zif.enable |=> !zif.mute)
    else $error("zero mute active while disabled");

  AST_ZERO_RUN: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R15]
    $rose(zif.mute) |-> $past(st_r.cnt) == ZERO_RUN - 10'h001 && $past(zif.frame_stb))
    else $error("zero mute raised off the run length");
endmodule
`default_nettype wire

// ==== sim/host_ctrl_model.sv ====
// host controller model that drives the control port pins
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
  // clock
  input wire logic clk_sys_i,
  // device pin drivers
  input wire logic ctrl_serial_out_i,
  input wire logic ctrl_serial_oe_i,
  input wire logic audio_pin_out_i,
  input wire logic audio_pin_oe_i,
  // resolved pin levels
  output logic ctrl_serial_clock_o,
  output logic ctrl_serial_in_o,
  output var logic addr_bit_pin_o,
  output logic audio_pin_level_o
);
  logic host_bit;
  logic strap_low;
  logic clk_pin;

  // idle: clock still, select high, line released, pin undriven
  initial begin
    clk_pin = 1'b0;
    host_bit = 1'b1;
    addr_bit_pin_o = 1'b1;
    strap_low = 1'b0;
  end
  assign ctrl_serial_clock_o = clk_pin;
  // line idles at the pull-up; device may only pull it low
  assign ctrl_serial_in_o = host_bit & ~(ctrl_serial_oe_i & ~ctrl_serial_out_i);
  // weak pull-up unless the strap resistor or the device drives it
  assign audio_pin_level_o = audio_pin_oe_i ? audio_pin_out_i : ~strap_low;

  // one bit, clock high and low 4 cycles each; od means released line goes high
  task automatic send_bit(input logic b, input logic od);
    @(negedge clk_sys_i);
    host_bit = b;
    repeat (4) @(negedge clk_sys_i);
    clk_pin = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    clk_pin = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    // old value must not linger once released
    host_bit = od ? 1'b1 : ~b;
  endtask

  // select low frames four-wire transfers, else address lsb
  task automatic set_select(input logic s);
    @(negedge clk_sys_i);
    addr_bit_pin_o = s;
  endtask

  task automatic set_strap(input logic low);
    @(negedge clk_sys_i);
    strap_low = low;
  endtask
endmodule
`default_nettype wire

// ==== sim/codec_mute_ctrl_tb_top.sv ====
// self-checking bench for the codec control-side block
`timescale 1ns/1ps
`default_nettype none
module codec_mute_ctrl_tb_top;
  import codec_ctrl_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic sclk, sin, apin, so, soe, aout, aoe, fw, alsb, csel, stb, bdata, act, lowp, rok, mute_n;
  logic addr;
  logic frame_clock_i = 1'b0;
  logic tx_en = 1'b0, tx_bit = 1'b0, high_rate_mode = 1'b1, pdn = 1'b0, mmute = 1'b0, zen = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [CH_NUM-1:0][SAMPLE_W-1:0] dac = '0;
  int error_cnt = 0, samples_checked = 0, cyc = 0, fp = 64, fcnt = 0, nstb = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  // frame clock of fp master cycles, synchronous, high first half
  always @(negedge clk_sys_i) begin
    fcnt = (fcnt + 1 >= fp) ? 0 : fcnt + 1;
    frame_clock_i <= (fcnt < fp / 2);
  end

  // count accepted bits; cut a hang short
  always @(posedge clk_sys_i) begin
    if (stb === 1'b1) nstb <= nstb + 1;
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      end_sim();
    end
  end

  host_ctrl_model i_host_ctrl_model (.clk_sys_i(clk_sys_i), .ctrl_serial_out_i(so), .ctrl_serial_oe_i(soe),
    .audio_pin_out_i(aout), .audio_pin_oe_i(aoe), .ctrl_serial_clock_o(sclk), .ctrl_serial_in_o(sin),
    .addr_bit_pin_o(addr), .audio_pin_level_o(apin));

  codec_mute_ctrl i_codec_mute_ctrl (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ctrl_serial_clock_i(sclk),
    .ctrl_serial_in_i(sin), .ctrl_serial_out_o(so), .ctrl_serial_oe_o(soe), .addr_bit_pin_i(addr),
    .audio_serial_out_i(apin), .audio_serial_out_o(aout), .audio_serial_out_oe_o(aoe),
    .audio_sdata_i(frame_clock_i), .frame_clock_i(frame_clock_i), .ctrl_tx_en_i(tx_en), .ctrl_tx_bit_i(tx_bit),
    .four_wire_mode_o(fw), .bus_addr_lsb_o(alsb), .ctrl_select_o(csel), .ctrl_bit_strobe_o(stb),
    .ctrl_bit_data_o(bdata), .clock_ratio_select_i(sel), .high_rate_mode_i(high_rate_mode), .power_down_i(pdn),
    .manual_mute_i(mmute), .zero_mute_enable_i(zen), .dac_data_i(dac), .codec_active_o(act),
    .low_power_o(lowp), .ratio_ok_o(rok), .mute_out_n_o(mute_n));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // settle past the 3-cycle detect plus 2-cycle mute path
  task automatic frames(input int n);
    repeat (n) @(posedge frame_clock_i);
    cyc_n(10);
  endtask

  task automatic wait_active;
    for (int k = 0; k < 40 && act !== 1'b1; k++) cyc_n(1);
    chk(24'(act), 24'h1);
  endtask

  // one control bit; taken says whether a strobe must follow
  task automatic put_bit(input logic b, input logic od, input logic taken);
    int n0;
    n0 = nstb;
    i_host_ctrl_model.send_bit(b, od);
    chk(24'(nstb - n0), 24'(taken));
    if (taken) chk(24'(bdata), 24'(b));
  endtask

  task automatic end_sim;
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    cyc_n(2);
    chk(24'(mute_n), 24'h0);
    chk(24'(lowp), 24'h1);
    chk(24'(act), 24'h0);
    reset_i = 1'b0;
    wait_active();
    chk(24'(fw), 24'h1);
    // four-wire: refused while deselected, taken when selected
    put_bit(1'b1, 1'b0, 1'b0);
    i_host_ctrl_model.set_select(1'b0);
    cyc_n(5);
    chk(24'(csel), 24'h1);
    put_bit(1'b1, 1'b0, 1'b1);
    put_bit(1'b0, 1'b0, 1'b1);
    tx_en = 1'b1;
    cyc_n(5);
    chk(24'(soe), 24'h0);
    chk(24'(alsb), 24'h0);
    tx_en = 1'b0;
    i_host_ctrl_model.set_select(1'b1);
    // every ratio of both rate tables
    for (int h = 0; h < 2; h++) begin
      for (int s = 0; s < 4; s++) begin
        high_rate_mode = h[0];
        sel = s[1:0];
        fp = (h == 1 ? 64 : 128) * (s + 1);
        frames(3);
        chk(24'(rok), 24'h1);
        chk(24'(mute_n), 24'h1);
      end
    end
    // frame length off the selected ratio
    sel = 2'h1;
    fp = 64;
    frames(3);
    chk(24'(rok), 24'h0);
    chk(24'(mute_n), 24'h0);
    sel = 2'h0;
    frames(3);
    chk(24'(mute_n), 24'h1);
    mmute = 1'b1;
    cyc_n(5);
    chk(24'(mute_n), 24'h0);
    mmute = 1'b0;
    cyc_n(5);
    chk(24'(mute_n), 24'h1);
    // silent frames count only once enabled
    frames(512);
    chk(24'(mute_n), 24'h1);
    zen = 1'b1;
    frames(511);
    chk(24'(mute_n), 24'h1);
    frames(1);
    chk(24'(mute_n), 24'h0);
    dac[5] = 24'h000001;
    frames(1);
    chk(24'(mute_n), 24'h1);
    zen = 1'b0;
    dac = '0;
    // power-down mutes, keeps the strap mode
    pdn = 1'b1;
    cyc_n(5);
    chk(24'(mute_n), 24'h0);
    chk(24'(act), 24'h0);
    pdn = 1'b0;
    wait_active();
    frames(3);
    chk(24'(mute_n), 24'h1);
    chk(24'(fw), 24'h1);
    // second reset with strap low; port deaf meanwhile
    i_host_ctrl_model.set_strap(1'b1);
    reset_i = 1'b1;
    put_bit(1'b1, 1'b1, 1'b0);
    chk(24'(lowp), 24'h1);
    chk(24'(fw), 24'h0);
    reset_i = 1'b0;
    wait_active();
    chk(24'(fw), 24'h0);
    i_host_ctrl_model.set_strap(1'b0);
    chk(24'(aoe), 24'h1);
    chk(24'(aout), 24'(frame_clock_i));
    // two-wire: address lsb, open-drain drive
    cyc_n(5);
    chk(24'(alsb), 24'h1);
    i_host_ctrl_model.set_select(1'b0);
    cyc_n(5);
    chk(24'(alsb), 24'h0);
    chk(24'(csel), 24'h0);
    put_bit(1'b0, 1'b1, 1'b1);
    tx_en = 1'b1;
    tx_bit = 1'b0;
    cyc_n(5);
    chk(24'(soe), 24'h1);
    chk(24'(so), 24'h0);
    tx_bit = 1'b1;
    cyc_n(5);
    chk(24'(soe), 24'h0);
    tx_en = 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
